//--- clear_edge.sv
`timescale 1ns/1ps
module clear_edge (
  // Stored and incoming clear bit
  input wire logic i_old_bit,
  input wire logic i_new_bit,
  input wire logic i_write,
  // Clear request
  output logic o_clear
);

  // Only a 0 to 1 transition of the stored bit asks for a clear
  always_comb begin
    o_clear = i_write && !i_old_bit && i_new_bit;
  end

endmodule

//--- level_decode.sv
`timescale 1ns/1ps
module level_decode #(
  parameter bit NEGATE = 1'b0
) (
  // Raw fields
  input wire logic [2:0] i_level_code,
  input wire logic [5:0] i_trim_code,
  // Decoded values
  output logic signed [2:0] o_steps,
  output logic o_special,
  output logic signed [5:0] o_trim_steps
);

  // Level code into signed 50 mV steps, negated for the under-voltage sense
  always_comb begin
    o_steps = trim_cfg_pkg::level_steps(i_level_code);
    if (NEGATE) begin
      o_steps = -trim_cfg_pkg::level_steps(i_level_code);
    end
    o_special = (i_level_code == trim_cfg_pkg::LEVEL_SPECIAL);
  end

  // Trim code into signed 0.6 mV steps; sign bit set gives positive offsets
  always_comb begin
    o_trim_steps = 6'sh00;
    if (i_trim_code[trim_cfg_pkg::TRIM_SIGN_BIT]) begin
      o_trim_steps = (i_trim_code[4:0] == 5'h00) ? 6'sh01 : $signed({1'b0, i_trim_code[4:0]});
    end else begin
      o_trim_steps = -$signed({1'b0, i_trim_code[4:0]});
    end
  end

endmodule

//--- protection_trim_config_regs.sv
`timescale 1ns/1ps
// Behaviour
// (RULE_01) Zero-cross trim is six bits at 5:0, 0.6 mV steps, top two bits reserved.
// (RULE_02) Trim resets to zero; sign bit set is positive, clear is negative.
// (RULE_03) Min-vout limit threshold is five bits at 5:1, 35 mV steps from 0.215 V.
// (RULE_04) Bit 0 enables min-vout gating of per-phase limit; reset clear.
// (RULE_05) Over-voltage code: 1..3 add, 5..7 subtract 50 mV steps; 0 nominal.
// (RULE_06) Over-voltage code 4 clamps protection to a fixed 2.0 V.
// (RULE_07) Under-voltage code: 1..3 subtract, 5..7 add; code 4 disables protection.
// (RULE_08) Thermal warning threshold is eight bits, resets to all ones.
// (RULE_09) Over-current status clears only on a 0 to 1 change of clear bit.
// (RULE_10) Clear register stays writable while the configuration lock is set.
// (RULE_11) Auxiliary bit 3 enables the ultrasonic timer; reset clear.
// (RULE_12) Auxiliary bit 2 selects bus-written settings over fuse settings.
// (RULE_13) Auxiliary bit 1 selects the current-limit trigger source.
// (RULE_14) Reserved bits read zero and writes to them do nothing.
module protection_trim_config_regs (
  // Clock, reset and enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Register port from the serial control interface
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Configuration lock from the lock block
  input wire logic i_lock,
  // Zero-cross detector trim
  output logic signed [5:0] o_zero_cross_trim_steps,
  // Minimum output voltage limit gate
  output logic o_min_vout_limit_gate_en,
  output logic [4:0] o_min_vout_limit_code,
  // Over- and under-voltage protection levels
  output logic signed [2:0] o_overvoltage_steps,
  output logic o_overvoltage_clamp,
  output logic signed [2:0] o_undervoltage_steps,
  output logic o_undervoltage_disable,
  // Thermal monitor warning level
  output logic [7:0] o_thermal_warning_level,
  // Over-current status clear pulse
  output logic o_overcurrent_status_clear,
  // Auxiliary options
  output logic o_ultrasonic_timer_enable,
  output logic o_settings_from_bus,
  output logic o_current_limit_trigger_select
);

  logic [5:0] trim_q, trim_d;
  logic [5:0] vmin_q, vmin_d;
  logic [2:0] ov_q, ov_d;
  logic [2:0] uv_q, uv_d;
  logic [7:0] therm_q, therm_d;
  logic clr_q, clr_d;
  logic [2:0] aux_q, aux_d;
  logic pulse_q, pulse_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic signed [5:0] trim_steps_q;
  logic signed [2:0] ov_steps_q, uv_steps_q;
  logic ov_clamp_q, uv_dis_q;
  logic signed [5:0] trim_steps_c;
  logic signed [2:0] ov_steps_c, uv_steps_c;
  logic ov_clamp_c, uv_dis_c;
  logic clear_req;
  logic cfg_wr;

  // Lock shields every register except the clear register
  assign cfg_wr = i_wr_en && !i_lock;

  // Transition detect on the clear bit, lock ignored
  clear_edge u_clear_edge (
    .i_old_bit(clr_q),
    .i_new_bit(i_wdata[trim_cfg_pkg::CLEAR_BIT]),
    .i_write(i_wr_en && (i_addr == trim_cfg_pkg::ADDR_STATUS_CLEAR_PULSE)),
    .o_clear(clear_req)
  );

  // Over-voltage level decode, plus zero-cross trim decode
  level_decode #(.NEGATE(1'b0)) u_ov_decode (
    .i_level_code(ov_q),
    .i_trim_code(trim_q),
    .o_steps(ov_steps_c),
    .o_special(ov_clamp_c),
    .o_trim_steps(trim_steps_c)
  );

  // Under-voltage level decode, opposite sense
  level_decode #(.NEGATE(1'b1)) u_uv_decode (
    .i_level_code(uv_q),
    .i_trim_code(trim_q),
    .o_steps(uv_steps_c),
    .o_special(uv_dis_c),
    .o_trim_steps()
  );

  // Register writes; only defined bits are stored
  always_comb begin
    trim_d = trim_q;
    vmin_d = vmin_q;
    ov_d = ov_q;
    uv_d = uv_q;
    therm_d = therm_q;
    clr_d = clr_q;
    aux_d = aux_q;
    pulse_d = clear_req; // RULE_09
    if (cfg_wr) begin
      case (i_addr)
        trim_cfg_pkg::ADDR_ZERO_CROSS_USER_TRIM: begin
          trim_d = i_wdata[5:0]; // RULE_01 RULE_14
        end
        trim_cfg_pkg::ADDR_MIN_VOUT_CURRENT_LIMIT_CFG: begin
          vmin_d = i_wdata[5:0]; // RULE_03 RULE_04
        end
        trim_cfg_pkg::ADDR_OVERVOLTAGE_THRESHOLD_CFG: begin
          ov_d = i_wdata[2:0]; // RULE_05
        end
        trim_cfg_pkg::ADDR_UNDERVOLTAGE_THRESHOLD_CFG: begin
          uv_d = i_wdata[2:0]; // RULE_07
        end
        trim_cfg_pkg::ADDR_THERMAL_WARNING_THRESHOLD: begin
          therm_d = i_wdata; // RULE_08
        end
        trim_cfg_pkg::ADDR_AUXILIARY_OPTIONS: begin
          aux_d = i_wdata[3:1]; // RULE_11 RULE_12 RULE_13
        end
        default: begin
          aux_d = aux_q;
        end
      endcase
    end
    if (i_wr_en && (i_addr == trim_cfg_pkg::ADDR_STATUS_CLEAR_PULSE)) begin
      clr_d = i_wdata[trim_cfg_pkg::CLEAR_BIT]; // RULE_10
    end
  end

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = i_rd_en;
    if (i_rd_en) begin
      case (i_addr)
        trim_cfg_pkg::ADDR_ZERO_CROSS_USER_TRIM: rdata_d = {2'h0, trim_q}; // RULE_14
        trim_cfg_pkg::ADDR_MIN_VOUT_CURRENT_LIMIT_CFG: rdata_d = {2'h0, vmin_q};
        trim_cfg_pkg::ADDR_OVERVOLTAGE_THRESHOLD_CFG: rdata_d = {5'h00, ov_q};
        trim_cfg_pkg::ADDR_UNDERVOLTAGE_THRESHOLD_CFG: rdata_d = {5'h00, uv_q};
        trim_cfg_pkg::ADDR_THERMAL_WARNING_THRESHOLD: rdata_d = therm_q;
        trim_cfg_pkg::ADDR_STATUS_CLEAR_PULSE: rdata_d = {7'h00, clr_q};
        trim_cfg_pkg::ADDR_AUXILIARY_OPTIONS: rdata_d = {4'h0, aux_q, 1'b0};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      trim_q <= trim_cfg_pkg::TRIM_RESET; // RULE_02
      vmin_q <= trim_cfg_pkg::VMIN_RESET;
      ov_q <= trim_cfg_pkg::LEVEL_RESET;
      uv_q <= trim_cfg_pkg::LEVEL_RESET;
      therm_q <= trim_cfg_pkg::THERM_RESET; // RULE_08
      clr_q <= 1'b0;
      aux_q <= trim_cfg_pkg::AUX_RESET;
      pulse_q <= 1'b0;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      trim_steps_q <= 6'sh00;
      ov_steps_q <= 3'sh0;
      uv_steps_q <= 3'sh0;
      ov_clamp_q <= 1'b0;
      uv_dis_q <= 1'b0;
    end else if (i_ce) begin
      trim_q <= trim_d;
      vmin_q <= vmin_d;
      ov_q <= ov_d;
      uv_q <= uv_d;
      therm_q <= therm_d;
      clr_q <= clr_d;
      aux_q <= aux_d;
      pulse_q <= pulse_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      trim_steps_q <= trim_steps_c; // RULE_02
      ov_steps_q <= ov_steps_c; // RULE_05
      uv_steps_q <= uv_steps_c; // RULE_07
      ov_clamp_q <= ov_clamp_c; // RULE_06
      uv_dis_q <= uv_dis_c; // RULE_07
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_zero_cross_trim_steps = trim_steps_q;
  assign o_min_vout_limit_gate_en = vmin_q[trim_cfg_pkg::VMIN_EN_BIT]; // RULE_04
  assign o_min_vout_limit_code = vmin_q[5:trim_cfg_pkg::VMIN_CODE_LSB]; // RULE_03
  assign o_overvoltage_steps = ov_steps_q;
  assign o_overvoltage_clamp = ov_clamp_q;
  assign o_undervoltage_steps = uv_steps_q;
  assign o_undervoltage_disable = uv_dis_q;
  assign o_thermal_warning_level = therm_q;
  assign o_overcurrent_status_clear = pulse_q;
  assign o_ultrasonic_timer_enable = aux_q[trim_cfg_pkg::AUX_ULTRA_BIT - 1]; // RULE_11
  assign o_settings_from_bus = aux_q[trim_cfg_pkg::AUX_SRC_SEL_BIT - 1]; // RULE_12
  assign o_current_limit_trigger_select = aux_q[trim_cfg_pkg::AUX_CURRENT_LIMIT_TRIGGER_SELECT_BIT - 1]; // RULE_13

  // Checks on the registered behaviour
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_trim_positive: assert property ((i_ce && trim_q == 6'h20) |=> o_zero_cross_trim_steps == 6'sh01) // RULE_01
    else $error("trim code 0x20 did not give one positive step");
  a_trim_reset: assert property ($past(i_reset) |-> (o_zero_cross_trim_steps == 6'sh00
    && o_thermal_warning_level == 8'hFF)) // RULE_02
    else $error("trim or thermal level wrong after reset");
  a_vmin_code: assert property ((i_ce && cfg_wr && i_addr == trim_cfg_pkg::ADDR_MIN_VOUT_CURRENT_LIMIT_CFG)
    |=> o_min_vout_limit_code == $past(i_wdata[5:1])) // RULE_03
    else $error("min vout code not stored");
  a_vmin_gate: assert property ((i_ce && cfg_wr && i_addr == trim_cfg_pkg::ADDR_MIN_VOUT_CURRENT_LIMIT_CFG)
    |=> o_min_vout_limit_gate_en == $past(i_wdata[0])) // RULE_04
    else $error("min vout gate enable not stored");
  a_ov_steps: assert property ((i_ce && ov_q == 3'h7) |=> o_overvoltage_steps == -3'sh3) // RULE_05
    else $error("over-voltage code 7 not minus three steps");
  a_ov_clamp: assert property ((i_ce && ov_q == 3'h4) |=> (o_overvoltage_clamp && o_overvoltage_steps == 3'sh0)) // RULE_06
    else $error("over-voltage clamp missing");
  a_uv_decode: assert property ((i_ce && uv_q == 3'h1) |=> (o_undervoltage_steps == -3'sh1
    && !o_undervoltage_disable)) // RULE_07
    else $error("under-voltage code 1 not minus one step");
  a_clear_pulse: assert property ((i_ce && i_wr_en && i_addr == trim_cfg_pkg::ADDR_STATUS_CLEAR_PULSE
    && i_wdata[0] && !clr_q) |=> o_overcurrent_status_clear) // RULE_09
    else $error("clear pulse missing on rising write");
  a_no_repeat_clear: assert property ((i_ce && i_wr_en && clr_q) |=> !o_overcurrent_status_clear) // RULE_09
    else $error("clear pulse without a rising bit");
  a_clear_under_lock: assert property ((i_ce && i_lock && i_wr_en && i_addr == trim_cfg_pkg::ADDR_STATUS_CLEAR_PULSE)
    |=> clr_q == $past(i_wdata[0])) // RULE_10
    else $error("clear register blocked by lock");
  a_lock_holds: assert property ((i_ce && i_lock) |=> $stable(therm_q) && $stable(aux_q)) // RULE_10
    else $error("locked register changed");
  a_aux_options: assert property ((i_ce && cfg_wr && i_addr == trim_cfg_pkg::ADDR_AUXILIARY_OPTIONS)
    |=> ({o_ultrasonic_timer_enable, o_settings_from_bus, o_current_limit_trigger_select}
    == $past(i_wdata[3:1]))) // RULE_11 RULE_12 RULE_13
    else $error("auxiliary options not stored");
  a_rsvd_read: assert property ((i_ce && i_rd_en && i_addr == trim_cfg_pkg::ADDR_OVERVOLTAGE_THRESHOLD_CFG)
    |=> (o_rvalid && o_rdata[7:3] == 5'h00)) // RULE_14
    else $error("reserved bits read nonzero");

  // Trim decode at both ends of the code range, and the stored field
  a_trim_negative: assert property ((i_ce && trim_q == 6'h1F) |=> o_zero_cross_trim_steps == -6'sh1F) // RULE_02
    else $error("trim code 0x1F did not give minus thirty-one steps");
  a_trim_full: assert property ((i_ce && trim_q == 6'h3F) |=> o_zero_cross_trim_steps == 6'sh1F) // RULE_02
    else $error("trim code 0x3F did not give thirty-one steps");
  a_trim_store: assert property ((i_ce && cfg_wr && i_addr == trim_cfg_pkg::ADDR_ZERO_CROSS_USER_TRIM) // RULE_01
    |=> trim_q == $past(i_wdata[5:0]))
    else $error("trim code not stored");

  // Level decode in the opposite directions, and the thermal level store
  a_ov_add: assert property ((i_ce && ov_q == 3'h3) |=> (o_overvoltage_steps == 3'sh3 // RULE_05
    && !o_overvoltage_clamp))
    else $error("over-voltage code 3 not plus three steps");
  a_uv_disable: assert property ((i_ce && uv_q == 3'h4) |=> (o_undervoltage_disable // RULE_07
    && o_undervoltage_steps == 3'sh0))
    else $error("under-voltage code 4 did not disable");
  a_uv_add: assert property ((i_ce && uv_q == 3'h7) |=> o_undervoltage_steps == 3'sh3) // RULE_07
    else $error("under-voltage code 7 not plus three steps");
  a_therm_store: assert property ((i_ce && cfg_wr // RULE_08
    && i_addr == trim_cfg_pkg::ADDR_THERMAL_WARNING_THRESHOLD) |=> o_thermal_warning_level == $past(i_wdata))
    else $error("thermal level not stored");

  // A zero written to the clear bit only rearms it
  a_clear_rearm: assert property ((i_ce && i_wr_en && i_addr == trim_cfg_pkg::ADDR_STATUS_CLEAR_PULSE // RULE_09
    && !i_wdata[0]) |=> !o_overcurrent_status_clear)
    else $error("clear pulse on a zero write");

  // Read strobe answered by a one-cycle valid; undefined bits read zero
  a_read_valid: assert property ((i_ce && i_rd_en) |=> o_rvalid) // RULE_14
    else $error("read not answered");
  a_idle_valid: assert property ((i_ce && !i_rd_en) |=> !o_rvalid) // RULE_14
    else $error("valid without a read");
  a_aux_rsvd_read: assert property ((i_ce && i_rd_en && i_addr == trim_cfg_pkg::ADDR_AUXILIARY_OPTIONS) // RULE_14
    |=> (o_rdata[7:4] == 4'h0 && !o_rdata[0]))
    else $error("auxiliary reserved bits read nonzero");
  a_trim_rsvd: assert property ((i_ce && i_rd_en && i_addr == trim_cfg_pkg::ADDR_ZERO_CROSS_USER_TRIM) // RULE_14
    |=> o_rdata[7:6] == 2'h0)
    else $error("trim reserved bits read nonzero");

  // Clock enable low freezes stored state and the clear strobe
  a_ce_freeze: assert property (!i_ce |=> ($stable(therm_q) && $stable(clr_q) // RULE_08 RULE_09
    && $stable(o_overcurrent_status_clear)))
    else $error("state moved with clock enable low");

  c_clear_seen: cover property (o_overcurrent_status_clear);
  c_ov_clamp: cover property (o_overvoltage_clamp);
  c_uv_disable: cover property (o_undervoltage_disable);
  c_locked_clear: cover property (i_lock ##1 o_overcurrent_status_clear);
  c_frozen_write: cover property (!i_ce && i_wr_en);

endmodule

//--- protection_trim_config_regs_test.sv
`timescale 1ns/1ps
module protection_trim_config_regs_test;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_ce = 1'b1;
  logic i_lock = 1'b0;
  logic [7:0] i_addr, i_wdata, o_rdata, o_thermal_warning_level;
  logic i_wr_en, i_rd_en, o_rvalid, o_min_vout_limit_gate_en, o_overvoltage_clamp, o_undervoltage_disable;
  logic o_overcurrent_status_clear, o_ultrasonic_timer_enable, o_settings_from_bus, o_current_limit_trigger_select;
  logic signed [5:0] o_zero_cross_trim_steps;
  logic [4:0] o_min_vout_limit_code;
  logic signed [2:0] o_overvoltage_steps, o_undervoltage_steps;
  logic [7:0] mdl [8];
  logic [7:0] mask [8] = '{8'h3F, 8'h3F, 8'h07, 8'h07, 8'hFF, 8'h01, 8'h0E, 8'h00};
  logic [7:0] trims [6] = '{8'h20, 8'h3F, 8'h1F, 8'h01, 8'hC0, 8'hE5};
  logic [7:0] clrs [6] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'hFE, 8'hFF};
  logic clr_lk [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed;

  protection_trim_config_regs u_protection_trim_config_regs (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_lock(i_lock), .o_zero_cross_trim_steps(o_zero_cross_trim_steps),
    .o_min_vout_limit_gate_en(o_min_vout_limit_gate_en), .o_min_vout_limit_code(o_min_vout_limit_code),
    .o_overvoltage_steps(o_overvoltage_steps), .o_overvoltage_clamp(o_overvoltage_clamp),
    .o_undervoltage_steps(o_undervoltage_steps), .o_undervoltage_disable(o_undervoltage_disable),
    .o_thermal_warning_level(o_thermal_warning_level), .o_overcurrent_status_clear(o_overcurrent_status_clear),
    .o_ultrasonic_timer_enable(o_ultrasonic_timer_enable), .o_settings_from_bus(o_settings_from_bus),
    .o_current_limit_trigger_select(o_current_limit_trigger_select));

  reg_host_model u_reg_host_model (.i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en));

  // Clock and hang guard
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Signed step count of a level code; neg swaps the direction
  function automatic logic [2:0] lvl(input logic [2:0] c, input logic neg);
    logic [2:0] m;
    m = {1'b0, c[1:0]};
    if (c == 3'h4) return 3'h0;
    if (c[2] ^ neg) return -m;
    return m;
  endfunction

  // Compare every configuration output with the model
  task automatic check_outs;
    logic [5:0] t;
    t = mdl[0][5] ? ((mdl[0][4:0] == 5'h00) ? 6'h01 : {1'b0, mdl[0][4:0]}) : -{1'b0, mdl[0][4:0]};
    check({2'h0, o_zero_cross_trim_steps}, {2'h0, t});
    check({7'h0, o_min_vout_limit_gate_en}, {7'h0, mdl[1][0]});
    check({3'h0, o_min_vout_limit_code}, {3'h0, mdl[1][5:1]});
    check({5'h0, o_overvoltage_steps}, {5'h0, lvl(mdl[2][2:0], 1'b0)});
    check({7'h0, o_overvoltage_clamp}, {7'h0, mdl[2][2:0] == 3'h4});
    check({5'h0, o_undervoltage_steps}, {5'h0, lvl(mdl[3][2:0], 1'b1)});
    check({7'h0, o_undervoltage_disable}, {7'h0, mdl[3][2:0] == 3'h4});
    check(o_thermal_warning_level, mdl[4]);
    check({4'h0, o_ultrasonic_timer_enable, o_settings_from_bus, o_current_limit_trigger_select, 1'b0},
      mdl[6]);
  endtask

  // Write one register, then check outputs and read back
  task automatic do_write(input int idx, input logic [7:0] d, input logic lk);
    logic [7:0] r;
    logic v;
    @(posedge i_clk);
    i_lock <= lk;
    u_reg_host_model.write_byte(8'h4D + idx[7:0], d);
    if (!lk) mdl[idx] = d & mask[idx];
    @(posedge i_clk);
    #1;
    check_outs;
    u_reg_host_model.read_byte(8'h4D + idx[7:0], r, v);
    check(r, mdl[idx]);
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0] r;
    logic v;
    logic p;
    int idx;
    seed = 71;
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int k = 0; k < 8; k++) mdl[k] = (k == 4) ? 8'hFF : 8'h00;
    @(posedge i_clk);
    #1;
    check_outs;
    for (int k = 0; k < 8; k++) begin
      u_reg_host_model.read_byte(8'h4D + k[7:0], r, v);
      check(r, mdl[k]);
      check({7'h0, v}, 8'h01);
    end
    for (int k = 0; k < 6; k++) do_write(0, trims[k], 1'b0);
    for (int c = 0; c < 8; c++) begin
      do_write(2, {5'h1F, c[2:0]}, 1'b0);
      do_write(3, {5'h15, c[2:0]}, 1'b0);
    end
    for (int k = 0; k < 200; k++) begin
      idx = {$random(seed)} % 7;
      if (idx == 5) idx = 6;
      do_write(idx, 8'($random(seed)), $random(seed) % 3 == 0);
    end
    for (int k = 0; k < 6; k++) begin
      p = !mdl[5][0] && clrs[k][0];
      @(posedge i_clk);
      i_lock <= clr_lk[k];
      u_reg_host_model.write_byte(8'h52, clrs[k]);
      mdl[5] = clrs[k] & 8'h01;
      #1;
      check({7'h0, o_overcurrent_status_clear}, {7'h0, p});
      @(posedge i_clk);
      #1;
      check({7'h0, o_overcurrent_status_clear}, 8'h00);
      u_reg_host_model.read_byte(8'h52, r, v);
      check(r, mdl[5]);
    end
    // Clock enable low: a write is dropped and every output holds
    @(posedge i_clk);
    i_lock <= 1'b0;
    i_ce <= 1'b0;
    u_reg_host_model.write_byte(8'h51, ~mdl[4]);
    @(posedge i_clk);
    i_ce <= 1'b1;
    #1;
    check_outs;
    u_reg_host_model.read_byte(8'h51, r, v);
    check(r, mdl[4]);
    print_verdict;
  end
endmodule

//--- reg_host_model.sv
`timescale 1ns/1ps
module reg_host_model (
  // Clock
  input wire logic i_clk,
  // Read answer
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  // Register port requests
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr_en,
  output logic o_rd_en
);
  // Idle port at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
  end

  // Byte write held for one taken edge; released lines show inverted data
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr_en <= 1'b1;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  // Byte read; answer sampled after the edge that registers it
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd_en <= 1'b1;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

//--- trim_cfg_pkg.sv
package trim_cfg_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_ZERO_CROSS_USER_TRIM = 8'h4D;
  localparam logic [7:0] ADDR_MIN_VOUT_CURRENT_LIMIT_CFG = 8'h4E;
  localparam logic [7:0] ADDR_OVERVOLTAGE_THRESHOLD_CFG = 8'h4F;
  localparam logic [7:0] ADDR_UNDERVOLTAGE_THRESHOLD_CFG = 8'h50;
  localparam logic [7:0] ADDR_THERMAL_WARNING_THRESHOLD = 8'h51;
  localparam logic [7:0] ADDR_STATUS_CLEAR_PULSE = 8'h52;
  localparam logic [7:0] ADDR_AUXILIARY_OPTIONS = 8'h53;

  // Field widths
  localparam int TRIM_W = 6;
  localparam int VMIN_W = 6;
  localparam int LEVEL_W = 3;
  localparam int THERM_W = 8;

  // Field positions
  localparam int TRIM_SIGN_BIT = 5;
  localparam int VMIN_EN_BIT = 0;
  localparam int VMIN_CODE_LSB = 1;
  localparam int CLEAR_BIT = 0;
  localparam int AUX_CURRENT_LIMIT_TRIGGER_SELECT_BIT = 1;
  localparam int AUX_SRC_SEL_BIT = 2;
  localparam int AUX_ULTRA_BIT = 3;

  // Reset values
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [5:0] VMIN_RESET = 6'h00;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic [7:0] THERM_RESET = 8'hFF;
  localparam logic [2:0] AUX_RESET = 3'h0;

  // Special level code: clamp for over-voltage, disable for under-voltage
  localparam logic [2:0] LEVEL_SPECIAL = 3'h4;

  // Signed 50 mV steps of a level code; positive for codes 1..3
  function automatic logic signed [2:0] level_steps(input logic [2:0] code);
    logic signed [2:0] s;
    s = 3'sh0;
    if (code[2] == 1'b0) begin
      s = $signed(code);
    end else if (code != LEVEL_SPECIAL) begin
      s = -$signed({1'b0, code[1:0]});
    end
    return s;
  endfunction

endpackage
